// *** rtl/adcr_pkg.sv ***
/*
 * Constants, register map and result formatting for the converter
 * control block.
 * Assumes an AHB-Lite fabric with 32-bit data and a 100 MHz hclk.
 */
package adcr_pkg;
	// byte offsets, one aligned word each
	localparam logic [7:0] OFF_RES_LO = 8'h00;
	localparam logic [7:0] OFF_RES_HI = 8'h04;
	localparam logic [7:0] OFF_CTRL0 = 8'h08;
	localparam logic [7:0] OFF_CTRL1 = 8'h0C;
	localparam logic [7:0] OFF_CTRL2 = 8'h10;
	localparam logic [7:0] OFF_BGAP = 8'h14;
	// field positions
	localparam int START_BIT = 7;
	localparam int BUSY_BIT = 6;
	localparam int EN_BIT = 5;
	localparam int ALIGN_BIT = 4;
	localparam int BGAP_BIT = 0;
	// writable bits per register
	localparam logic [7:0] CTRL0_MASK = 8'hBF;
	localparam logic [7:0] CTRL1_MASK = 8'hF7;
	localparam logic [7:0] CTRL2_MASK = 8'h9F;
	localparam logic [7:0] BGAP_MASK = 8'h01;
	localparam logic [7:0] REG_RESET = 8'h00;
	// converter shape and timing
	localparam int RES_BITS = 12;
	localparam int NUM_CHAN = 10;
	localparam logic [3:0] LAST_CHAN = 4'h9;
	localparam logic [2:0] SAMPLE_TICKS = 3'h4;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum {SAR_IDLE, SAR_SAMPLE, SAR_DECIDE} adcr_sar_e;

	function automatic logic [7:0] fmt_hi(input logic [11:0] d,
		input logic align);
		fmt_hi = align ? {4'h0, d[11:8]} : d[11:4];
	endfunction

	function automatic logic [7:0] fmt_lo(input logic [11:0] d,
		input logic align);
		fmt_lo = align ? d[7:0] : {d[3:0], 4'h0};
	endfunction
endpackage

// *** rtl/adcr_sar.sv ***
/*
 * Successive-approximation sequencer with the conversion clock divider.
 * Assumes an analog comparator that is high while the input is at or
 * above the trial code on dac_code.
 */
module adcr_sar import adcr_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// control
	input wire logic start,
	input wire logic enable,
	input wire logic [2:0] clk_div,
	input wire logic cmp_in,
	// results
	output logic [11:0] dac_code,
	output logic sampling,
	output logic done,
	output logic [11:0] result
);
	typedef struct packed {
		adcr_sar_e state;
		logic [6:0] div_cnt;
		logic [2:0] samp_cnt;
		logic [3:0] idx;
		logic [11:0] code;
		logic sampling;
		logic done;
		logic [11:0] result;
	} adcr_sar_s;

	adcr_sar_s r_reg;
	adcr_sar_s r_next;
	logic [6:0] mask;
	logic tick;
	logic [11:0] kept;

	assign mask = 7'((8'h01 << clk_div) - 8'h01);
	// tick once every 2**clk_div system clocks
	assign tick = ((r_reg.div_cnt & mask) == mask);
	assign kept = cmp_in ? r_reg.code
		: r_reg.code & ~(12'h001 << r_reg.idx);

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		r_next.div_cnt = 7'(r_reg.div_cnt + 7'h01);
		case (r_reg.state)
			SAR_IDLE: begin
				if (start && enable) begin
					r_next.state = SAR_SAMPLE;
					r_next.div_cnt = 7'h00;
					r_next.samp_cnt = 3'h0;
					r_next.sampling = 1'b1;
				end
			end
			SAR_SAMPLE: begin
				if (tick) begin
					r_next.samp_cnt = 3'(r_reg.samp_cnt + 3'h1);
					if (r_next.samp_cnt == SAMPLE_TICKS) begin
						r_next.sampling = 1'b0;
						r_next.state = SAR_DECIDE;
						r_next.idx = 4'hB;
						r_next.code = 12'h800;
					end
				end
			end
			SAR_DECIDE: begin
				// fixed length: one decision per divided tick
				if (tick) begin
					if (r_reg.idx == 4'h0) begin
						r_next.result = kept;
						r_next.done = 1'b1;
						r_next.code = 12'h000;
						r_next.state = SAR_IDLE;
					end else begin
						r_next.idx = 4'(r_reg.idx - 4'h1);
						r_next.code = kept | (12'h001 << r_next.idx);
					end
				end
			end
			default: r_next.state = SAR_IDLE;
		endcase
		// powering down abandons the conversion and drops done; result changes only if the last decision falls in that cycle
		if (!enable) begin
			r_next.state = SAR_IDLE;
			r_next.sampling = 1'b0;
			r_next.done = 1'b0;
			r_next.code = 12'h000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign dac_code = r_reg.code;
	assign sampling = r_reg.sampling;
	assign done = r_reg.done;
	assign result = r_reg.result;
endmodule

// *** rtl/adcr_top.sv ***
/*
 * Converter control and result registers behind an AHB-Lite slave,
 * with input routing, reference controls and the SAR sequencer.
 * Assumes one master, zero-wait single word transfers, and that the
 * pin-share logic reports which pins are taken as analog inputs.
 */
module adcr_top import adcr_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// analog front end
	input wire logic cmp_in,
	input wire logic [9:0] pin_adc_req,
	output logic conv_power,
	output logic ext_path_en,
	output logic [9:0] ext_chan_sel,
	output logic src_supply,
	output logic src_amp,
	output logic src_ground,
	output logic [1:0] src_scale,
	output logic [9:0] pin_analog,
	output logic [11:0] dac_code,
	output logic sampling,
	// reference controls
	output logic amp_enable,
	output logic amp_input_sel,
	output logic [1:0] ref_sel,
	output logic [1:0] amp_gain_sel,
	output logic bandgap_en
);
	typedef struct packed {
		logic [7:0] c0;
		logic [7:0] c1;
		logic [7:0] c2;
		logic [7:0] bg;
		logic [11:0] result;
		logic busy;
		logic launch;
		logic clr_pend;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic ready;
		logic [9:0] ext_sel;
		logic ext_en;
		logic power;
		logic supply;
		logic amp_src;
		logic ground;
		logic [1:0] scale;
		logic [9:0] pin_analog;
	} adcr_regs_s;

	adcr_regs_s r_reg;
	adcr_regs_s r_next;
	logic rd_req;
	logic wr_req;
	logic start_seq;
	logic [7:0] rd_byte;
	logic [3:0] src;
	logic [3:0] chan;
	logic sar_done;
	logic [11:0] sar_result;

	assign rd_req = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	assign wr_req = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
	// start falls on a write that keeps the converter enabled
	assign start_seq = r_reg.wr_pend && r_reg.wr_addr == OFF_CTRL0
		&& r_reg.c0[START_BIT] && !hwdata[START_BIT]
		&& hwdata[EN_BIT] && !r_reg.busy;

	always_comb begin
		r_next = r_reg;
		rd_byte = 8'h00;
		src = 4'h0;
		chan = 4'h0;
		r_next.launch = 1'b0;
		r_next.ready = 1'b1;
		// data phase of a write: the bus gives hwdata now
		if (r_reg.wr_pend) begin
			if (r_reg.wr_addr == OFF_CTRL0) begin
				// busy position is masked off the write
				r_next.c0 = hwdata[7:0] & CTRL0_MASK;
			end else if (r_reg.wr_addr == OFF_CTRL1) begin
				r_next.c1 = hwdata[7:0] & CTRL1_MASK;
			end else if (r_reg.wr_addr == OFF_CTRL2) begin
				r_next.c2 = hwdata[7:0] & CTRL2_MASK;
			end else if (r_reg.wr_addr == OFF_BGAP) begin
				r_next.bg = hwdata[7:0] & BGAP_MASK;
			end
		end
		if (start_seq) begin
			r_next.busy = 1'b1;
			r_next.launch = 1'b1;
		end
		// busy drops one cycle after the result lands
		if (r_reg.clr_pend) begin
			r_next.busy = 1'b0;
			r_next.clr_pend = 1'b0;
		end
		// a done that lands just after power-down must not overwrite
		if (sar_done && r_reg.power) begin
			r_next.result = sar_result;
			r_next.clr_pend = 1'b1;
		end
		// switching off aborts; the result changes only if a done lands in that same cycle
		if (!r_next.c0[EN_BIT]) begin
			r_next.busy = 1'b0;
			r_next.clr_pend = 1'b0;
		end
		r_next.power = r_next.c0[EN_BIT];
		// input routing
		src = r_next.c1[7:4];
		chan = r_next.c0[3:0];
		r_next.ext_en = (src == 4'h0) || (src == 4'h4)
			|| (src[3:2] == 2'h3);
		r_next.ground = (src[3:2] == 2'h2);
		r_next.supply = !src[3] && !src[2] && src[1:0] != 2'h0;
		r_next.amp_src = !src[3] && src[2] && src[1:0] != 2'h0;
		// 1 full, 2 half, 3 quarter, coded as scale 0, 1, 2
		r_next.scale = (r_next.supply || r_next.amp_src)
			? 2'(src[1:0] - 2'h1) : 2'h0;
		r_next.ext_sel = 10'h000;
		if (r_next.ext_en && chan <= LAST_CHAN) begin
			r_next.ext_sel = 10'h001 << chan;
		end
		// codes above nine leave every channel switch open
		if (chan > LAST_CHAN) begin
			r_next.ext_sel = 10'h000;
		end
		r_next.pin_analog = pin_adc_req;
		// register read sees the write of the previous data phase
		if (haddr[7:0] == OFF_RES_LO) begin
			rd_byte = fmt_lo(r_next.result, r_next.c0[ALIGN_BIT]);
		end else if (haddr[7:0] == OFF_RES_HI) begin
			rd_byte = fmt_hi(r_next.result, r_next.c0[ALIGN_BIT]);
		end else if (haddr[7:0] == OFF_CTRL0) begin
			rd_byte = r_next.c0;
			rd_byte[BUSY_BIT] = r_next.busy;
		end else if (haddr[7:0] == OFF_CTRL1) begin
			rd_byte = r_next.c1;
		end else if (haddr[7:0] == OFF_CTRL2) begin
			rd_byte = r_next.c2;
		end else if (haddr[7:0] == OFF_BGAP) begin
			rd_byte = r_next.bg;
		end
		if (rd_req) begin
			r_next.rdata = {24'h000000, rd_byte};
		end
		r_next.wr_pend = wr_req;
		r_next.wr_addr = haddr[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	adcr_sar u_sar (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(r_reg.launch),
		.enable(r_reg.power),
		.clk_div(r_reg.c1[2:0]),
		.cmp_in(cmp_in),
		.dac_code(dac_code),
		.sampling(sampling),
		.done(sar_done),
		.result(sar_result)
	);

	assign hreadyout = r_reg.ready;
	assign hresp = 1'b0;
	assign hrdata = r_reg.rdata;
	assign conv_power = r_reg.power;
	assign ext_path_en = r_reg.ext_en;
	assign ext_chan_sel = r_reg.ext_sel;
	assign src_supply = r_reg.supply;
	assign src_amp = r_reg.amp_src;
	assign src_ground = r_reg.ground;
	assign src_scale = r_reg.scale;
	assign pin_analog = r_reg.pin_analog;
	assign amp_enable = r_reg.c2[7];
	assign amp_input_sel = r_reg.c2[4];
	assign ref_sel = r_reg.c2[3:2];
	assign amp_gain_sel = r_reg.c2[1:0];
	assign bandgap_en = r_reg.bg[BGAP_BIT];

	// checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence start_fall_s;
		start_seq;
	endsequence

	sequence result_then_idle_s;
		sar_done ##1 (r_reg.result == $past(sar_result) && r_reg.busy)
			##1 !r_reg.busy;
	endsequence

	property busy_follows_start_p;
		start_fall_s |=> r_reg.busy && r_reg.launch;
	endproperty

	property done_order_p;
		sar_done && r_reg.power && r_next.power |-> result_then_idle_s;
	endproperty

	busy_on_start_a: assert property (busy_follows_start_p)
		else $error("busy not set after start sequence");

	done_order_a: assert property (done_order_p)
		else $error("busy cleared before result written");

	busy_origin_a: assert property (
		$rose(r_reg.busy) |-> $past(start_seq))
		else $error("busy rose without a start sequence");

	hold_off_a: assert property (
		!r_reg.power && !$past(r_reg.power) |-> $stable(r_reg.result))
		else $error("result changed while disabled");

	fmt_read_a: assert property (
		rd_req && haddr[7:0] == OFF_RES_HI && !r_next.c0[ALIGN_BIT]
		|=> hrdata == {24'h000000, r_reg.result[11:4]})
		else $error("high result misformatted");

	fmt_lo_a: assert property (
		rd_req && haddr[7:0] == OFF_RES_LO && r_next.c0[ALIGN_BIT]
		|=> hrdata == {24'h000000, r_reg.result[7:0]})
		else $error("low result misformatted");

	unused_zero_a: assert property (
		$past(rd_req) && $past(haddr[7:0]) == OFF_RES_LO
		&& !r_reg.c0[ALIGN_BIT] && !$past(r_reg.wr_pend)
		|-> hrdata[3:0] == 4'h0)
		else $error("unused result bits not zero");

	ext_off_a: assert property (
		!r_reg.ext_en |-> r_reg.ext_sel == 10'h000)
		else $error("external path on with internal source");

	bad_chan_a: assert property (
		r_reg.c0[3:0] > LAST_CHAN |-> r_reg.ext_sel == 10'h000)
		else $error("channel switch closed for absent input");

	ctrl1_bit3_a: assert property (
		$past(rd_req) && $past(haddr[7:0]) == OFF_CTRL1
		|-> hrdata[3] == 1'b0)
		else $error("reserved bit reads nonzero");

	power_a: assert property (
		!r_reg.c0[EN_BIT] |-> !r_reg.power && !r_reg.busy)
		else $error("converter powered while disabled");
endmodule

// *** verif/adcr_tb.sv ***
/*
 * Self-checking bench for the converter control block.
 * Assumes zero-wait AHB-Lite answers; the comparator is an ideal model.
 */
module testbench import adcr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// bus and front end
	logic hclk, hresetn, hsel, hwrite, cmp_in, hreadyout, hresp, rd_ph;
	logic [31:0] haddr, hwdata, hrdata, seed, exp_q[$], msk_q[$];
	logic [1:0] htrans, src_scale, ref_sel, amp_gain_sel;
	logic [2:0] hsize;
	logic [9:0] pin_adc_req, pin_analog, ext_chan_sel;
	logic conv_power, ext_path_en, src_supply, src_amp, src_ground;
	logic [11:0] dac_code, vin;
	logic sampling, amp_enable, amp_input_sel, bandgap_en;
	logic [7:0] wd[7] = '{8'hFF, 8'hFF, 8'h5F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	logic [7:0] ex[7] = '{8'h00, 8'h00, 8'h1F, 8'hF7, 8'h9F, 8'h01, 8'h00};
	int miscompares, checked, cyc;

	// comparator high while the input is at or above the trial code
	assign cmp_in = (vin >= dac_code);

	adcr_top uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .cmp_in(cmp_in), .pin_adc_req(pin_adc_req),
		.conv_power(conv_power), .ext_path_en(ext_path_en),
		.ext_chan_sel(ext_chan_sel), .src_supply(src_supply),
		.src_amp(src_amp), .src_ground(src_ground), .src_scale(src_scale),
		.pin_analog(pin_analog), .dac_code(dac_code), .sampling(sampling),
		.amp_enable(amp_enable), .amp_input_sel(amp_input_sel),
		.ref_sel(ref_sel), .amp_gain_sel(amp_gain_sel),
		.bandgap_en(bandgap_en)
	);

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	always @(posedge hclk) cyc <= cyc + 1;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected routing: {ext, supply, amp, ground, scale, channel switch}
	function automatic logic [15:0] route(input logic [3:0] s,
		input logic [3:0] c);
		logic e, su, am;
		e = s == 4'h0 || s == 4'h4 || s[3:2] == 2'h3;
		su = s inside {4'h1, 4'h2, 4'h3};
		am = s inside {4'h5, 4'h6, 4'h7};
		route = {e, su, am, s[3:2] == 2'h2,
			(su || am) ? s[1:0] - 2'h1 : 2'h0,
			(e && c <= 4'h9) ? 10'h001 << c : 10'h000};
	endfunction

	task automatic conclude();
		if (miscompares == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a hung bus counts as a mismatch
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			conclude();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= 1'b1;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy();
	endtask

	// mask 0 only polls; upper bus bits must always read zero
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m, output logic [7:0] d);
		exp_q.push_back({24'h0, e});
		msk_q.push_back({24'hFFFFFF, m});
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= 1'b0;
		wait_rdy();
		htrans <= 2'h0;
		wait_rdy();
		d = hrdata[7:0];
	endtask

	always @(posedge hclk) begin
		if (hresetn && hreadyout === 1'b1) begin
			if (rd_ph && exp_q.size() > 0) begin
				chk(hrdata & msk_q[0], exp_q[0] & msk_q[0]);
				chk(32'(hresp), 32'h0);
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
			rd_ph = hsel && htrans == HTRANS_NONSEQ && !hwrite;
		end
	end

	task automatic conv(input logic [2:0] dv);
		logic [7:0] al, rv;
		int t0, n;
		al = {3'h0, dv[0], 4'h0};
		vin <= 12'(rnd());
		wr(OFF_CTRL1, {5'h0, dv});
		wr(OFF_CTRL0, 8'h20 | al);
		rd(OFF_CTRL0, 8'h20 | al, 8'hFF, rv);
		chk(32'(conv_power), 32'h1);
		wr(OFF_CTRL0, 8'hA0 | al);
		wr(OFF_CTRL0, 8'h20 | al);
		t0 = cyc;
		rd(OFF_CTRL0, 8'h60 | al, 8'hFF, rv);
		chk(32'(sampling), 32'h1);
		n = 0;
		do begin
			rd(OFF_CTRL0, 8'h00, 8'h00, rv);
			n++;
		end while (rv[BUSY_BIT] && n < 2000);
		if (rv[BUSY_BIT] !== 1'b0) begin
			miscompares++;
			conclude();
		end
		chk(32'({sampling, dac_code}), 32'h0);
		n = cyc - t0;
		chk(32'(n >= (16 << dv) && n <= (16 << dv) + 16), 32'h1);
		for (int a = 0; a < 2; a++) begin
			wr(OFF_CTRL0, 8'h20 | 8'(a << 4));
			rd(OFF_RES_LO, a ? vin[7:0] : {vin[3:0], 4'h0}, 8'hFF, rv);
			rd(OFF_RES_HI, a ? {4'h0, vin[11:8]} : vin[11:4], 8'hFF, rv);
		end
	endtask

	initial begin
		logic [7:0] rv;
		logic [9:0] p;
		logic [11:0] old;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pin_adc_req = 10'h0;
		vin = 12'h0;
		seed = 32'd88781;
		rd_ph = 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 7; i++)
			rd(8'(i * 4), 8'h00, 8'hFF, rv);
		// bandgap on and settled before the amplifier may pick it
		wr(OFF_BGAP, 8'h01);
		repeat (20) @(posedge hclk);
		for (int i = 0; i < 7; i++) begin
			wr(8'(i * 4), wd[i]);
			rd(8'(i * 4), ex[i], 8'hFF, rv);
		end
		@(posedge hclk);
		chk(32'({amp_enable, amp_input_sel, ref_sel, amp_gain_sel,
			bandgap_en}), 32'h7F);
		for (int s = 0; s < 16; s++)
			for (int c = 0; c < 16; c++) begin
				wr(OFF_CTRL1, 8'(s << 4));
				wr(OFF_CTRL0, 8'(c));
				@(posedge hclk);
				chk(32'({ext_path_en, src_supply, src_amp, src_ground,
					src_scale, ext_chan_sel}), 32'(route(4'(s), 4'(c))));
			end
		repeat (8) begin
			p = 10'(rnd());
			pin_adc_req <= p;
			repeat (2) @(posedge hclk);
			chk(32'(pin_analog), 32'(p));
		end
		for (int dv = 0; dv < 8; dv++)
			conv(3'(dv));
		// abort a running conversion, then try to start while disabled
		old = vin;
		vin <= ~old;
		wr(OFF_CTRL0, 8'hA0);
		wr(OFF_CTRL0, 8'h20);
		wr(OFF_CTRL0, 8'h00);
		wr(OFF_CTRL0, 8'h80);
		wr(OFF_CTRL0, 8'h00);
		rd(OFF_CTRL0, 8'h00, 8'hFF, rv);
		chk(32'(conv_power), 32'h0);
		rd(OFF_RES_LO, {old[3:0], 4'h0}, 8'hFF, rv);
		rd(OFF_RES_HI, old[11:4], 8'hFF, rv);
		@(posedge hclk);
		conclude();
	end
endmodule
